//--- hdl/output_port_with_clock_out.sv
// twelve-bit output port with timer and oscillator clock outputs
// assumes cpu writes arrive as core-clock strobes; clocks come from pins
`timescale 1ns/10ps
`include "outport_map.svh"
module output_port_with_clock_out
	import outport_pkg::*;
#(
	parameter bit GROUP1_OPEN_DRAIN = 1'b0,
	parameter bit GROUP2_OPEN_DRAIN = 1'b0
) (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input outport_pkg::port_wr_s i_wr,
	input wire logic i_timer_clk,
	input wire logic i_low_speed_osc_clk,
	input wire logic i_high_speed_osc_clk,
	output logic [11:0] o_pin_out,
	output logic [11:0] o_pin_oe_n,
	output outport_pkg::port_state_s o_state
);
	import outport_pkg::*;

	// ------------------------------------------------------------------
	// stored control state
	// ------------------------------------------------------------------
	port_state_s ctl_q;
	port_state_s ctl_d;
	port_state_s state_q;
	logic [11:0] pin_out_q;
	logic [11:0] pin_out_d;
	logic [11:0] pin_oe_n_q;
	logic [11:0] pin_oe_n_d;

	// ------------------------------------------------------------------
	// clock inputs from outside the core domain
	// ------------------------------------------------------------------
	logic timer_lvl;
	logic ls_lvl;
	logic hs_lvl;
	logic ls_div8;
	logic ls_div64;

	pin_sync u_sync_timer (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_async(i_timer_clk),
		.o_level(timer_lvl)
	);

	pin_sync u_sync_ls (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_async(i_low_speed_osc_clk),
		.o_level(ls_lvl)
	);

	pin_sync u_sync_hs (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_async(i_high_speed_osc_clk),
		.o_level(hs_lvl)
	);

	ls_clk_divider u_ls_div (
		.i_core_clk(i_core_clk),
		.i_srst(i_srst),
		.i_level(ls_lvl),
		.o_div8(ls_div8),
		.o_div64(ls_div64)
	);

	// ------------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------------
	wire [3:0] grp0_d = i_wr.out_group0.we ?
		i_wr.out_group0.data : ctl_q.out_group0;
	wire [3:0] grp1_d = i_wr.out_group1.we ?
		i_wr.out_group1.data : ctl_q.out_group1;
	wire [3:0] grp2_d = i_wr.out_group2.we ?
		i_wr.out_group2.data : ctl_q.out_group2;
	wire [3:0] fbits_d = i_wr.float_ctl_bits.we ?
		i_wr.float_ctl_bits.data : ctl_q.float_ctl_bits;
	wire fg1_d = i_wr.float_ctl_group1.we ?
		i_wr.float_ctl_group1.data : ctl_q.float_ctl_group1;
	wire fg2_d = i_wr.float_ctl_group2.we ?
		i_wr.float_ctl_group2.data : ctl_q.float_ctl_group2;
	wire spc_we = i_wr.special.we;
	wire ten_d = spc_we ?
		i_wr.special.timer_clock_out_en : ctl_q.timer_clock_out_en;
	wire oen_d = spc_we ?
		i_wr.special.osc_clock_out_en : ctl_q.osc_clock_out_en;
	wire [1:0] freq_d = spc_we ?
		i_wr.special.osc_out_freq_sel : ctl_q.osc_out_freq_sel;

	assign ctl_d = '{
		out_group0: grp0_d,
		out_group1: grp1_d,
		out_group2: grp2_d,
		float_ctl_bits: fbits_d,
		float_ctl_group1: fg1_d,
		float_ctl_group2: fg2_d,
		timer_clock_out_en: ten_d,
		osc_clock_out_en: oen_d,
		osc_out_freq_sel: freq_d
	};

	// ------------------------------------------------------------------
	// oscillator clock selection
	// ------------------------------------------------------------------
	wire sel_hs = (freq_d == `OUTPORT_FREQ_HS);
	wire sel_ls = (freq_d == `OUTPORT_FREQ_LS);
	wire sel_d8 = (freq_d == `OUTPORT_FREQ_DIV8);
	// 00 falls through to the divide-by-64 tap
	wire osc_clock_out = sel_hs ? hs_lvl :
		sel_ls ? ls_lvl :
		sel_d8 ? ls_div8 : ls_div64;
	wire timer_clock_out = timer_lvl;

	// ------------------------------------------------------------------
	// terminal levels
	// ------------------------------------------------------------------
	// special clocks are gated by the data bit, so writing 0 forces low;
	// enable changes are not synchronised to the clock, a runt may appear
	wire lvl2 = ten_d ? (grp0_d[`OUTPORT_TIMER_BIT] & timer_clock_out) :
		grp0_d[`OUTPORT_TIMER_BIT];
	wire lvl3 = oen_d ? (grp0_d[`OUTPORT_OSC_BIT] & osc_clock_out) :
		grp0_d[`OUTPORT_OSC_BIT];
	wire [3:0] lvl0 = {lvl3, lvl2, grp0_d[1:0]};

	// open-drain releases the pin for a high level
	wire [3:0] od1_rel = GROUP1_OPEN_DRAIN ? grp1_d : 4'h0;
	wire [3:0] od2_rel = GROUP2_OPEN_DRAIN ? grp2_d : 4'h0;

	assign pin_out_d = {grp2_d, grp1_d, lvl0};
	assign pin_oe_n_d = {
		{4{fg2_d}} | od2_rel,
		{4{fg1_d}} | od1_rel,
		fbits_d
	};

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			ctl_q <= '{
				out_group0: `OUTPORT_DATA_RST,
				out_group1: `OUTPORT_DATA_RST,
				out_group2: `OUTPORT_DATA_RST,
				float_ctl_bits: `OUTPORT_FLOAT_BITS_RST,
				float_ctl_group1: `OUTPORT_FLOAT_GRP_RST,
				float_ctl_group2: `OUTPORT_FLOAT_GRP_RST,
				timer_clock_out_en: `OUTPORT_SPC_EN_RST,
				osc_clock_out_en: `OUTPORT_SPC_EN_RST,
				osc_out_freq_sel: `OUTPORT_FREQ_RST
			};
		end else begin
			ctl_q <= ctl_d;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			pin_out_q <= 12'hfff;
			pin_oe_n_q <= {GROUP2_OPEN_DRAIN ? 4'hf : 4'h0,
				GROUP1_OPEN_DRAIN ? 4'hf : 4'h0, 4'h0};
		end else begin
			pin_out_q <= pin_out_d;
			pin_oe_n_q <= pin_oe_n_d;
		end
	end

	assign state_q = ctl_q;
	assign o_state = state_q;
	assign o_pin_out = pin_out_q;
	assign o_pin_oe_n = pin_oe_n_q;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_srst);

	wire run = !i_srst;

	chk_reset_drive: assert property (
		$past(i_srst) |-> o_pin_out[3:0] == 4'hf && o_pin_oe_n[3:0] == 4'h0
	) else $error("group 0 not driving high after reset");

	chk_reset_mode: assert property (
		$past(i_srst) |-> !ctl_q.timer_clock_out_en &&
			!ctl_q.osc_clock_out_en
	) else $error("special output selected after reset");

	chk_write_to_pin: assert property (
		i_wr.out_group1.we && !fg1_d && !GROUP1_OPEN_DRAIN
			|=> o_pin_out[7:4] == $past(i_wr.out_group1.data) &&
			o_pin_oe_n[7:4] == 4'h0
	) else $error("group 1 write not seen on pins next cycle");

	chk_float_group: assert property (
		ctl_q.float_ctl_group2 |-> o_pin_oe_n[11:8] == 4'hf
	) else $error("group 2 drives while floated");

	chk_float_bit: assert property (
		i_wr.float_ctl_bits.we ##1 run |-> o_pin_oe_n[3:0] ==
			$past(i_wr.float_ctl_bits.data)
	) else $error("group 0 float bits not applied");

	chk_force_low: assert property (
		!ctl_q.out_group0[`OUTPORT_TIMER_BIT] &&
			!ctl_q.float_ctl_bits[`OUTPORT_TIMER_BIT]
			|-> !o_pin_out[`OUTPORT_TIMER_BIT] &&
			!o_pin_oe_n[`OUTPORT_TIMER_BIT]
	) else $error("timer terminal not forced low");

	chk_special_float: assert property (
		ctl_q.osc_clock_out_en && ctl_q.float_ctl_bits[`OUTPORT_OSC_BIT]
			|-> o_pin_oe_n[`OUTPORT_OSC_BIT]
	) else $error("oscillator terminal not floated");

	chk_timer_pass: assert property (
		ctl_q.timer_clock_out_en && ctl_q.out_group0[`OUTPORT_TIMER_BIT]
			|-> o_pin_out[`OUTPORT_TIMER_BIT] == $past(timer_lvl)
	) else $error("timer clock not on terminal");

	chk_osc_hs: assert property (
		ctl_q.osc_clock_out_en && ctl_q.out_group0[`OUTPORT_OSC_BIT] &&
			ctl_q.osc_out_freq_sel == `OUTPORT_FREQ_HS
			|-> o_pin_out[`OUTPORT_OSC_BIT] == $past(hs_lvl)
	) else $error("high-speed clock not on terminal");

	chk_osc_div8: assert property (
		ctl_q.osc_clock_out_en && ctl_q.out_group0[`OUTPORT_OSC_BIT] &&
			ctl_q.osc_out_freq_sel == `OUTPORT_FREQ_DIV8
			|-> o_pin_out[`OUTPORT_OSC_BIT] == $past(ls_div8)
	) else $error("divide-by-8 clock not on terminal");

	chk_open_drain: assert property (
		GROUP2_OPEN_DRAIN && ctl_q.out_group2[0] |-> o_pin_oe_n[8]
	) else $error("open-drain group drives high");

	chk_group_data: assert property (
		o_pin_out[11:4] == {ctl_q.out_group2, ctl_q.out_group1} &&
			o_pin_out[1:0] == ctl_q.out_group0[1:0]
	) else $error("plain terminals differ from data bits");

	chk_timer_off: assert property (
		!ctl_q.timer_clock_out_en |-> o_pin_out[`OUTPORT_TIMER_BIT] ==
			ctl_q.out_group0[`OUTPORT_TIMER_BIT]
	) else $error("timer terminal not following data");

	chk_osc_off: assert property (
		!ctl_q.osc_clock_out_en |-> o_pin_out[`OUTPORT_OSC_BIT] ==
			ctl_q.out_group0[`OUTPORT_OSC_BIT]
	) else $error("oscillator terminal not following data");

	chk_osc_ls: assert property (
		ctl_q.osc_clock_out_en && ctl_q.out_group0[`OUTPORT_OSC_BIT] &&
			ctl_q.osc_out_freq_sel == `OUTPORT_FREQ_LS
			|-> o_pin_out[`OUTPORT_OSC_BIT] == $past(ls_lvl)
	) else $error("low-speed clock not on terminal");

	chk_osc_div64: assert property (
		ctl_q.osc_clock_out_en && ctl_q.out_group0[`OUTPORT_OSC_BIT] &&
			ctl_q.osc_out_freq_sel == `OUTPORT_FREQ_DIV64
			|-> o_pin_out[`OUTPORT_OSC_BIT] == $past(ls_div64)
	) else $error("divide-by-64 clock not on terminal");

	chk_od_drive_low: assert property (
		GROUP1_OPEN_DRAIN && !ctl_q.float_ctl_group1 &&
			!ctl_q.out_group1[0] |-> !o_pin_oe_n[4] && !o_pin_out[4]
	) else $error("open-drain group not pulling low");

	cov_timer_toggle: cover property (
		ctl_q.timer_clock_out_en ##1 $rose(o_pin_out[`OUTPORT_TIMER_BIT])
	);
	cov_div64_toggle: cover property (
		ctl_q.osc_clock_out_en &&
			ctl_q.osc_out_freq_sel == `OUTPORT_FREQ_DIV64
			##1 $fell(o_pin_out[`OUTPORT_OSC_BIT])
	);
	cov_group2_float: cover property (
		$rose(o_pin_oe_n[11])
	);
	cov_hs_toggle: cover property (
		ctl_q.osc_clock_out_en && ctl_q.osc_out_freq_sel == `OUTPORT_FREQ_HS
			##1 $rose(o_pin_out[`OUTPORT_OSC_BIT])
	);
endmodule

//--- common/outport_map.svh
// constants of the twelve-bit output port: reset values, codes, widths
// assumes inclusion by bare name from the package and the design files
`ifndef OUTPORT_MAP_SVH
`define OUTPORT_MAP_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define OUTPORT_PINS 12
`define OUTPORT_GROUP_BITS 4
`define OUTPORT_DIV_BITS 6

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define OUTPORT_DATA_RST 4'hf
`define OUTPORT_FLOAT_BITS_RST 4'h0
`define OUTPORT_FLOAT_GRP_RST 1'h0
`define OUTPORT_SPC_EN_RST 1'h0
`define OUTPORT_FREQ_RST 2'h0

// ----------------------------------------------------------------------
// oscillator output frequency select codes
// ----------------------------------------------------------------------
`define OUTPORT_FREQ_HS 2'h3
`define OUTPORT_FREQ_LS 2'h2
`define OUTPORT_FREQ_DIV8 2'h1
`define OUTPORT_FREQ_DIV64 2'h0

// ----------------------------------------------------------------------
// divider taps on the low-speed edge counter
// ----------------------------------------------------------------------
`define OUTPORT_TAP_DIV8 2
`define OUTPORT_TAP_DIV64 5

// ----------------------------------------------------------------------
// terminal positions inside group 0
// ----------------------------------------------------------------------
`define OUTPORT_TIMER_BIT 2
`define OUTPORT_OSC_BIT 3

`endif

//--- common/outport_pkg.sv
// types of the twelve-bit output port
// assumes outport_map.svh on the include path
package outport_pkg;
	`include "outport_map.svh"

	typedef logic [1:0] osc_freq_t;

	// one four-bit write, strobe and value
	typedef struct packed {
		logic we;
		logic [3:0] data;
	} nib_wr_s;

	// single-bit write, strobe and value
	typedef struct packed {
		logic we;
		logic data;
	} bit_wr_s;

	// special output control write
	typedef struct packed {
		logic we;
		logic timer_clock_out_en;
		logic osc_clock_out_en;
		osc_freq_t osc_out_freq_sel;
	} spc_wr_s;

	// every cpu write towards the port
	typedef struct packed {
		nib_wr_s out_group0;
		nib_wr_s out_group1;
		nib_wr_s out_group2;
		nib_wr_s float_ctl_bits;
		bit_wr_s float_ctl_group1;
		bit_wr_s float_ctl_group2;
		spc_wr_s special;
	} port_wr_s;

	// readback of the stored control state
	typedef struct packed {
		logic [3:0] out_group0;
		logic [3:0] out_group1;
		logic [3:0] out_group2;
		logic [3:0] float_ctl_bits;
		logic float_ctl_group1;
		logic float_ctl_group2;
		logic timer_clock_out_en;
		logic osc_clock_out_en;
		osc_freq_t osc_out_freq_sel;
	} port_state_s;
endpackage

//--- hdl/pin_sync.sv
// three-stage synchroniser for a level from outside the core clock
// assumes a free-running core clock and a synchronous reset
`timescale 1ns/10ps
module pin_sync (
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_async,
	output logic o_level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;
	wire agree = (s2_q == s3_q);

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_q <= 1'b0;
		end else begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (agree) begin
				level_q <= s3_q;
			end
		end
	end

	assign o_level = level_q;
endmodule

//--- hdl/ls_clk_divider.sv
// divides the synchronised low-speed clock by 8 and by 64
// assumes a level already synchronised to the core clock
`timescale 1ns/10ps
`include "outport_map.svh"
module ls_clk_divider
	import outport_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_srst,
	input wire logic i_level,
	output logic o_div8,
	output logic o_div64
);
	logic prev_q;
	logic [`OUTPORT_DIV_BITS-1:0] cnt_q;
	logic [`OUTPORT_DIV_BITS-1:0] cnt_d;
	wire rise = i_level & ~prev_q;

	// each counter bit k toggles once per 2**k rising edges
	assign cnt_d = rise ? cnt_q + 6'h1 : cnt_q;

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			prev_q <= 1'b0;
			cnt_q <= 6'h0;
		end else begin
			prev_q <= i_level;
			cnt_q <= cnt_d;
		end
	end

	assign o_div8 = cnt_q[`OUTPORT_TAP_DIV8];
	assign o_div64 = cnt_q[`OUTPORT_TAP_DIV64];
endmodule

//--- tb/pin_receiver_model.sv
// receiving side of the twelve output pins: resolves levels, counts edges
// assumes pins are sampled on the core clock; a released pin has no pull
`timescale 1ns/10ps
module pin_receiver_model (
	input wire logic i_core_clk,
	input wire logic i_clear,
	input wire logic [11:0] i_pin_out,
	input wire logic [11:0] i_pin_oe_n,
	output logic [11:0] o_level,
	output logic [15:0] o_rise2,
	output logic [15:0] o_rise3,
	output logic [15:0] o_drive2
);
	logic [11:0] last_q;
	logic [11:0] rose;
	logic [15:0] rise2_q;
	logic [15:0] rise3_q;
	logic [15:0] drive2_q;

	// a released pin shows the inverse of its last level, never a held one
	assign o_level = (~i_pin_oe_n & i_pin_out) |
		(i_pin_oe_n & ~last_q);
	assign rose = ~i_pin_oe_n & o_level & ~last_q;
	assign o_rise2 = rise2_q;
	assign o_rise3 = rise3_q;
	assign o_drive2 = drive2_q;

	always_ff @(posedge i_core_clk) begin
		// track the level through a clear so no false edge follows it
		last_q <= o_level;
		if (i_clear) begin
			rise2_q <= 16'h0000;
			rise3_q <= 16'h0000;
			drive2_q <= 16'h0000;
		end else begin
			rise2_q <= rise2_q + 16'(rose[2]);
			rise3_q <= rise3_q + 16'(rose[3]);
			drive2_q <= drive2_q + 16'(!i_pin_oe_n[2]);
		end
	end
endmodule

//--- tb/output_port_with_clock_out_tb_top.sv
// self-checking bench for the twelve-bit output port
// assumes the design files, the package and the pin receiver model
`timescale 1ns/10ps
module output_port_with_clock_out_tb_top;
	import outport_pkg::*;

	logic i_core_clk;
	logic i_srst;
	port_wr_s i_wr;
	logic i_timer_clk;
	logic i_low_speed_osc_clk;
	logic i_high_speed_osc_clk;
	logic [11:0] pin_out;
	logic [11:0] pin_oe_n;
	port_state_s state;
	logic [11:0] od_out;
	logic [11:0] od_oe_n;
	logic clear;
	logic [11:0] level;
	logic [15:0] rise2;
	logic [15:0] rise3;
	logic [15:0] drive2;
	int num_errors;
	int total_checks;
	int src_cnt;
	int exp3[4];
	port_wr_s w;
	localparam port_state_s state_rst = '{4'hf, 4'hf, 4'hf, 4'h0, 1'b0,
		1'b0, 1'b0, 1'b0, 2'h0};

	output_port_with_clock_out uut (.i_core_clk(i_core_clk), .i_srst(i_srst),
		.i_wr(i_wr), .i_timer_clk(i_timer_clk),
		.i_low_speed_osc_clk(i_low_speed_osc_clk),
		.i_high_speed_osc_clk(i_high_speed_osc_clk),
		.o_pin_out(pin_out), .o_pin_oe_n(pin_oe_n), .o_state(state));
	output_port_with_clock_out #(.GROUP1_OPEN_DRAIN(1'b1),
		.GROUP2_OPEN_DRAIN(1'b1)) uut_od (.i_core_clk(i_core_clk),
		.i_srst(i_srst), .i_wr(i_wr), .i_timer_clk(i_timer_clk),
		.i_low_speed_osc_clk(i_low_speed_osc_clk),
		.i_high_speed_osc_clk(i_high_speed_osc_clk),
		.o_pin_out(od_out), .o_pin_oe_n(od_oe_n), .o_state());
	pin_receiver_model model (.i_core_clk(i_core_clk), .i_clear(clear),
		.i_pin_out(pin_out), .i_pin_oe_n(pin_oe_n), .o_level(level),
		.o_rise2(rise2), .o_rise3(rise3), .o_drive2(drive2));

	// ------------------------------------------------------------------
	// clocks: core, and the three sources stepped on the falling edge
	// ------------------------------------------------------------------
	initial begin
		i_core_clk = 1'b0;
		forever #12.5 i_core_clk = ~i_core_clk;
	end

	// timer period 16 cycles, low-speed 10, high-speed 8
	always @(negedge i_core_clk) begin
		src_cnt <= src_cnt + 1;
		if (src_cnt % 8 == 7) i_timer_clk <= ~i_timer_clk;
		if (src_cnt % 5 == 4) i_low_speed_osc_clk <= ~i_low_speed_osc_clk;
		if (src_cnt % 4 == 3) i_high_speed_osc_clk <= ~i_high_speed_osc_clk;
	end

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// edge counts may be off by one at the window boundaries
	task automatic near(input logic [15:0] seen, input int exp);
		if (seen >= exp - 1 && seen <= exp + 1) check(exp, exp);
		else check(seen, exp);
	endtask

	task automatic go(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask

	task automatic put(input port_wr_s v);
		@(negedge i_core_clk);
		i_wr <= v;
		@(negedge i_core_clk);
		i_wr <= '0;
	endtask

	task automatic measure();
		go(6);
		clear <= 1'b1;
		go(1);
		clear <= 1'b0;
		go(1280);
	endtask

	task automatic reset_check();
		check(pin_out, 12'hfff);
		check(pin_oe_n, 12'h000);
		check(state, state_rst);
		check(od_oe_n, 12'hff0);
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		i_srst = 1'b1;
		i_wr = '0;
		clear = 1'b1;
		src_cnt = 0;
		i_timer_clk = 1'b0;
		i_low_speed_osc_clk = 1'b0;
		i_high_speed_osc_clk = 1'b0;
		num_errors = 0;
		total_checks = 0;
		exp3 = '{2, 16, 128, 160};
		go(2);
		i_srst <= 1'b0;
		go(1);
		reset_check();
		w = '0;
		w.out_group0 = '{1'b1, 4'h5};
		w.out_group1 = '{1'b1, 4'ha};
		w.out_group2 = '{1'b1, 4'h3};
		put(w);
		check(pin_out, 12'h3a5);
		check(level, 12'h3a5);
		check(od_oe_n, 12'h3a0);
		check(od_out[11:4] & ~od_oe_n[11:4], 8'h00);
		for (int i = 0; i < 4; i++) begin
			w = '0;
			w.float_ctl_bits = '{1'b1, 4'(1 << i)};
			put(w);
			check(pin_oe_n, 12'(1 << i));
		end
		w = '0;
		w.float_ctl_bits = '{1'b1, 4'h0};
		w.float_ctl_group1 = '{1'b1, 1'b1};
		put(w);
		check(pin_oe_n, 12'h0f0);
		w = '0;
		w.float_ctl_group1 = '{1'b1, 1'b0};
		w.float_ctl_group2 = '{1'b1, 1'b1};
		put(w);
		check(pin_oe_n, 12'hf00);
		w.float_ctl_group2 = '{1'b1, 1'b0};
		put(w);
		check(pin_oe_n, 12'h000);
		// data held at 1, float at 0 while a clock is used
		w = '0;
		w.out_group0 = '{1'b1, 4'hf};
		put(w);
		// the timer source runs from time zero
		w = '0;
		w.special = '{1'b1, 1'b1, 1'b0, 2'h0};
		put(w);
		check(state.timer_clock_out_en, 1'b1);
		measure();
		near(rise2, 80);
		check(rise3, 16'h0000);
		w = '0;
		w.out_group0 = '{1'b1, 4'hb};
		put(w);
		measure();
		check(rise2, 16'h0000);
		check(pin_out[2], 1'b0);
		w.out_group0 = '{1'b1, 4'hf};
		w.float_ctl_bits = '{1'b1, 4'h4};
		put(w);
		measure();
		check(drive2, 16'h0000);
		w = '0;
		w.float_ctl_bits = '{1'b1, 4'h0};
		w.special = '{1'b1, 1'b0, 1'b0, 2'h0};
		put(w);
		measure();
		check(rise2, 16'h0000);
		check(pin_out[2], 1'b1);
		// the high-speed source runs from time zero
		for (int c = 0; c < 4; c++) begin
			w.special = '{1'b1, 1'b0, 1'b1, 2'(c)};
			put(w);
			measure();
			near(rise3, exp3[c]);
		end
		w.special = '{1'b1, 1'b0, 1'b0, 2'h0};
		put(w);
		measure();
		check(rise3, 16'h0000);
		w.special = '{1'b1, 1'b1, 1'b1, 2'h3};
		w.out_group1 = '{1'b1, 4'h0};
		w.float_ctl_group2 = '{1'b1, 1'b1};
		put(w);
		i_srst <= 1'b1;
		go(2);
		reset_check();
		i_srst <= 1'b0;
		go(2);
		reset_check();
		wrap_up();
	end

	initial begin
		repeat (100000) @(posedge i_core_clk);
		num_errors++;
		wrap_up();
	end
endmodule
